// ===== verilog/abd_datapath.sv
// add and bit-clear datapath: executes five arithmetic/logic instructions on the accumulator,
// a file register and the status flags. assumes decode presents one instruction word, held
// stable across the four phases of each instruction cycle, and a file read port on the same clock.
`timescale 1ns/1ps
`default_nettype none

module abd_datapath (
	// clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_reset,
	// instruction from decode
	input  wire logic        i_instr_valid,
	input  wire logic [13:0] i_instr,
	// file register read data for the address on o_file_addr
	input  wire logic [7:0]  i_file_rdata,
	// file register access
	output logic      [6:0]  o_file_addr,
	output logic             o_file_we,
	output logic      [7:0]  o_file_wdata,
	// architectural state
	output logic      [7:0]  o_accumulator,
	output logic             o_carry_flag,
	output logic             o_nibble_carry_flag,
	output logic             o_zero_flag,
	// cycle timing
	output logic             o_cycle_start,
	output logic             o_instr_done,
	output logic             o_illegal
);

	typedef struct packed {
		logic [1:0] phase;
		logic [6:0] addr;
		logic       file_we;
		logic [7:0] file_wdata;
		logic [7:0] acc;
		logic       carry;
		logic       nib_carry;
		logic       zero;
		logic       cycle_start;
		logic       done;
		logic       illegal;
	} abd_state_s;

	abd_state_s state_reg;
	abd_state_s state_next;

	// instruction kinds this datapath executes; everything else is reported as illegal
	typedef enum logic [2:0] {
		OP_ILLEGAL,
		OP_ADD_LIT,
		OP_AND_LIT,
		OP_ADD_FILE,
		OP_AND_FILE,
		OP_CLR_BIT
	} abd_op_e;

	// the fields are fixed by the 14-bit format and the 2-bit phase counter;
	// a package edited out of step with the ports is refused here rather than mis-decoded
	if (abd_pkg::INSTR_W != 14 || abd_pkg::DATA_W != 8) begin : g_chk_width
		$error("abd_datapath: instruction or data width differs from the ports");
	end
	if (abd_pkg::ADDR_W != 7 || abd_pkg::BIT_IDX_W != 3) begin : g_chk_field
		$error("abd_datapath: address or bit index width differs from the ports");
	end
	if (abd_pkg::PHASES_PER_CYCLE != 4) begin : g_chk_phase
		$error("abd_datapath: phase counter is two bits and wraps after four");
	end

	function automatic logic [8:0] abd_add(input logic [7:0] a, input logic [7:0] b);
		abd_add = {1'b0, a} + {1'b0, b};
	endfunction

	function automatic logic abd_nib_carry(input logic [7:0] a, input logic [7:0] b);
		logic [4:0] s;
		s = {1'b0, a[3:0]} + {1'b0, b[3:0]};
		abd_nib_carry = s[4];
	endfunction

	// the opcode map lives here only, so the execute step reads as a plain list of kinds
	function automatic abd_op_e abd_decode(input logic [1:0] c, input logic [3:0] n);
		abd_op_e k;
		k = OP_ILLEGAL;
		if (c == abd_pkg::CLASS_LIT && n[3:1] == abd_pkg::NIB_ADD_LIT_HI) begin
			// the lowest nibble bit is a don't-care: both encodings add
			k = OP_ADD_LIT;
		end else if (c == abd_pkg::CLASS_LIT && n == abd_pkg::NIB_AND_LIT) begin
			k = OP_AND_LIT;
		end else if (c == abd_pkg::CLASS_BYTE && n == abd_pkg::NIB_ADD_FILE) begin
			k = OP_ADD_FILE;
		end else if (c == abd_pkg::CLASS_BYTE && n == abd_pkg::NIB_AND_FILE) begin
			k = OP_AND_FILE;
		end else if (c == abd_pkg::CLASS_BIT && n[3:2] == abd_pkg::NIB_CLR_BIT_HI) begin
			// the low two nibble bits are the top of the bit index, not opcode
			k = OP_CLR_BIT;
		end
		abd_decode = k;
	endfunction

	function automatic logic abd_is_zero(input logic [7:0] v);
		abd_is_zero = (v == 8'h00);
	endfunction

	logic [1:0] cls;
	logic [3:0] nib;
	logic [7:0] lit;
	logic       dest;
	logic [2:0] bidx;

	assign cls  = i_instr[abd_pkg::CLASS_HI:abd_pkg::CLASS_LO];
	assign nib  = i_instr[abd_pkg::NIB_HI:abd_pkg::NIB_LO];
	assign lit  = i_instr[abd_pkg::LIT_HI:0];
	assign dest = i_instr[abd_pkg::DEST_BIT];
	assign bidx = i_instr[abd_pkg::BIT_HI:abd_pkg::BIT_LO];

	always_comb begin
		logic [8:0] sum;
		logic [7:0] opnd;
		logic [7:0] res;
		logic       exec;
		abd_op_e    op;
		exec = 1'b0;
		op   = OP_ILLEGAL;
		sum  = '0;
		opnd = '0;
		res  = '0;
		state_next = state_reg;
		state_next.file_we     = 1'b0;
		state_next.done        = 1'b0;
		state_next.illegal     = 1'b0;
		// free-running phase counter, wraps after four periods
		state_next.phase       = state_reg.phase + 2'h1;
		state_next.cycle_start = (state_reg.phase == abd_pkg::PHASE_LAST);
		// address is registered from the word every period, so it is out from phase 1 and read data is settled by the last phase
		state_next.addr        = i_instr[abd_pkg::ADDR_HI:0];
		exec = i_instr_valid && (state_reg.phase == abd_pkg::PHASE_LAST);
		op   = abd_decode(cls, nib);
		if (exec) begin
			// execute in the last phase, one cycle per instruction
			state_next.done = 1'b1;
			opnd = (cls == abd_pkg::CLASS_LIT) ? lit : i_file_rdata;
			unique case (op)
				OP_ADD_LIT: begin
					sum = abd_add(state_reg.acc, opnd);
					state_next.acc       = sum[7:0];
					state_next.carry     = sum[8];
					state_next.nib_carry = abd_nib_carry(state_reg.acc, opnd);
					state_next.zero      = abd_is_zero(sum[7:0]);
				end
				OP_AND_LIT: begin
					res = state_reg.acc & opnd;
					// carry and nibble carry keep their values
					state_next.acc  = res;
					state_next.zero = abd_is_zero(res);
				end
				OP_ADD_FILE: begin
					sum = abd_add(state_reg.acc, opnd);
					state_next.carry     = sum[8];
					state_next.nib_carry = abd_nib_carry(state_reg.acc, opnd);
					state_next.zero      = abd_is_zero(sum[7:0]);
					// destination select
					if (dest) begin
						state_next.file_we    = 1'b1;
						state_next.file_wdata = sum[7:0];
					end else begin
						state_next.acc = sum[7:0];
					end
				end
				OP_AND_FILE: begin
					res = state_reg.acc & opnd;
					state_next.zero = abd_is_zero(res);
					if (dest) begin
						state_next.file_we    = 1'b1;
						state_next.file_wdata = res;
					end else begin
						state_next.acc = res;
					end
				end
				OP_CLR_BIT: begin
					// flags untouched; read-modify-write of one bit
					state_next.file_we    = 1'b1;
					state_next.file_wdata = opnd & ~(8'h01 << bidx);
				end
				OP_ILLEGAL: begin
					// not one of ours: no state change, and done stays low so decode
					// sees exactly one of the two reports
					state_next.done    = 1'b0;
					state_next.illegal = 1'b1;
				end
			endcase
		end
		if (i_reset) begin
			state_next = '0;
			state_next.phase = abd_pkg::PHASE_EXEC;
			state_next.acc   = abd_pkg::ACC_RESET;
			state_next.carry = abd_pkg::FLAG_RESET;
			state_next.nib_carry = abd_pkg::FLAG_RESET;
			state_next.zero  = abd_pkg::FLAG_RESET;
		end
	end

	always_ff @(posedge i_mclk) begin
		state_reg <= state_next;
	end

	assign o_file_addr         = state_reg.addr;
	assign o_file_we           = state_reg.file_we;
	assign o_file_wdata        = state_reg.file_wdata;
	assign o_accumulator       = state_reg.acc;
	assign o_carry_flag        = state_reg.carry;
	assign o_nibble_carry_flag = state_reg.nib_carry;
	assign o_zero_flag         = state_reg.zero;
	assign o_cycle_start       = state_reg.cycle_start;
	assign o_instr_done        = state_reg.done;
	assign o_illegal           = state_reg.illegal;

endmodule

`default_nettype wire

// ===== common/abd_pkg.sv
// package for the add and bit-clear datapath: opcode fields, reset values, timing.
// assumes a 14-bit instruction word and an 8-bit accumulator and file.
package abd_pkg;
	localparam int INSTR_W       = 14;
	localparam int DATA_W        = 8;
	localparam int ADDR_W        = 7;
	localparam int BIT_IDX_W     = 3;
	// one instruction cycle is this many oscillator periods
	localparam int PHASES_PER_CYCLE = 4;
	localparam logic [1:0] PHASE_LAST = 2'h3;
	localparam logic [1:0] PHASE_EXEC = 2'h0;
	// opcode class and field positions
	localparam int CLASS_HI      = 13;
	localparam int CLASS_LO      = 12;
	localparam int NIB_HI        = 11;
	localparam int NIB_LO        = 8;
	localparam int DEST_BIT      = 7;
	localparam int ADDR_HI       = 6;
	localparam int BIT_HI        = 9;
	localparam int BIT_LO        = 7;
	localparam int LIT_HI        = 7;
	localparam logic [1:0] CLASS_BYTE    = 2'h0;
	localparam logic [1:0] CLASS_BIT     = 2'h1;
	localparam logic [1:0] CLASS_LIT     = 2'h3;
	localparam logic [3:0] NIB_ADD_FILE  = 4'h7;
	localparam logic [3:0] NIB_AND_FILE  = 4'h5;
	localparam logic [3:0] NIB_AND_LIT   = 4'h9;
	localparam logic [2:0] NIB_ADD_LIT_HI = 3'h7;
	localparam logic [1:0] NIB_CLR_BIT_HI = 2'h0;
	// reset values
	localparam logic [7:0] ACC_RESET     = 8'h00;
	localparam logic       FLAG_RESET    = 1'h0;
endpackage

// ===== verif/abd_file_model.sv
// file register array beside the datapath
// assumes writes land on the rising edge while the strobe is high
`timescale 1ns/1ps
`default_nettype none
module abd_file_model (
	input  wire logic       i_mclk,
	input  wire logic [6:0] i_addr,
	input  wire logic       i_we,
	input  wire logic [7:0] i_wdata,
	output logic      [7:0] o_rdata
);
	logic [7:0] mem [128];
	initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 75);
	assign o_rdata = mem[i_addr];
	always @(posedge i_mclk) if (i_we) mem[i_addr] <= i_wdata;
endmodule
`default_nettype wire

// ===== verif/abd_datapath_sva.sv
// checker on the datapath ports
// bound into abd_datapath; one clock domain
`timescale 1ns/1ps
`default_nettype none
module abd_datapath_sva (input wire logic i_mclk, i_reset, i_instr_valid, o_file_we,
	input wire logic o_carry_flag, o_nibble_carry_flag, o_zero_flag, o_cycle_start,
	input wire logic o_instr_done, o_illegal, input wire logic [13:0] i_instr,
	input wire logic [7:0] i_file_rdata, o_file_wdata, o_accumulator);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_reset);
	wire logic [5:0] op = i_instr[13:8];
	wire logic       d  = o_instr_done;
	wire logic       lg = op[5:1] == 5'h1f || op == 6'h39 || op == 6'h07 || op == 6'h05
		|| op[5:2] == 4'h4;
	a_cycle_gap: assert property (
		o_cycle_start |=> !o_cycle_start [*3] ##1 o_cycle_start) else $error("cycle length");
	a_done_gap: assert property (
		d |-> $past(i_instr_valid && lg) ##1 !d [*3]) else $error("done spacing");
	a_illegal_src: assert property (
		o_illegal |-> $past(!lg) && $stable(o_accumulator) && !o_file_we) else $error("illegal");
	a_add_imm: assert property (
		d && $past(op[5:1] == 5'h1f) |-> {o_carry_flag, o_accumulator} == $past(o_accumulator)
		+ $past(i_instr[7:0]) && o_nibble_carry_flag == ($past(o_accumulator[3:0])
		+ $past(i_instr[3:0]) > 15)) else $error("add imm");
	a_and_imm: assert property (
		d && $past(op == 6'h39) |-> o_accumulator == ($past(o_accumulator) & $past(i_instr[7:0]))
		&& o_zero_flag == (o_accumulator == 0) && $stable(o_carry_flag)) else $error("and imm");
	a_add_file: assert property (
		d && $past(op == 6'h07) |-> {o_carry_flag, o_file_we ? o_file_wdata : o_accumulator}
		== $past(o_accumulator) + $past(i_file_rdata)) else $error("add file");
	a_dest_sel: assert property (
		d && $past(op[5:4] == 2'h0) |-> o_file_we == $past(i_instr[7])
		&& (!o_file_we || $stable(o_accumulator))) else $error("dest");
	a_and_file: assert property (
		d && $past(op == 6'h05) |-> o_zero_flag == (($past(o_accumulator)
		& $past(i_file_rdata)) == 0) && $stable(o_carry_flag)) else $error("and file");
	a_clear_bit: assert property (
		d && $past(op[5:2] == 4'h4) |-> o_file_we && o_file_wdata == ($past(i_file_rdata)
		& ~(8'h01 << $past(i_instr[9:7]))) && $stable(o_zero_flag)) else $error("clear bit");
	c_illegal: cover property (o_illegal);
	c_write: cover property (d && o_file_we);
	c_carry: cover property (d && o_carry_flag);
endmodule
`default_nettype wire

// ===== verif/abd_datapath_tb.sv
// bench: corner and random instructions, checked against a bench model
// assumes the file model answers reads combinationally
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
	$display("BAD %s exp %h got %h", n, e, g); end end
module abd_datapath_tb;
	logic        i_mclk = 0, i_reset = 1, i_instr_valid = 0;
	logic [13:0] i_instr = 0;
	wire logic [7:0] i_file_rdata, o_file_wdata, o_accumulator;
	wire logic [6:0] o_file_addr;
	wire logic   o_file_we, o_carry_flag, o_nibble_carry_flag, o_zero_flag;
	wire logic   o_cycle_start, o_instr_done, o_illegal;
	int          err_count = 0, checks_done = 0, seed = 5922, cyc = 0;
	logic [7:0]  acc = 0, f, r, b;
	logic [8:0]  s;
	logic [31:0] t;
	logic        c = 0, dc = 0, z = 0, we, ok;
	logic [13:0] ops [5] = '{14'h3e00, 14'h3900, 14'h0700, 14'h0500, 14'h1000};
	logic [13:0] msk [5] = '{14'h01ff, 14'h00ff, 14'h00ff, 14'h00ff, 14'h03ff};
	abd_datapath dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_instr_valid(i_instr_valid),
		.i_instr(i_instr), .i_file_rdata(i_file_rdata), .o_file_addr(o_file_addr),
		.o_file_we(o_file_we), .o_file_wdata(o_file_wdata), .o_accumulator(o_accumulator),
		.o_carry_flag(o_carry_flag), .o_nibble_carry_flag(o_nibble_carry_flag),
		.o_zero_flag(o_zero_flag), .o_cycle_start(o_cycle_start),
		.o_instr_done(o_instr_done), .o_illegal(o_illegal));
	abd_file_model mdl (.i_mclk(i_mclk), .i_addr(o_file_addr), .i_we(o_file_we),
		.i_wdata(o_file_wdata), .o_rdata(i_file_rdata));
	always #12.5 i_mclk = ~i_mclk;
	always @(posedge i_mclk) if (++cyc > 3000) begin err_count++; print_verdict(); end
	task automatic run(input logic [13:0] ins);
		int k = 0;
		logic ad, an, bc;
		i_instr = ins;
		i_instr_valid = 1;
		do begin @(negedge i_mclk); k++; end while (!(o_instr_done | o_illegal) && k < 8);
		`CHK("addr", ins[6:0], o_file_addr)
		`CHK("cycle start", 1'b1, o_cycle_start)
		f = mdl.mem[ins[6:0]];
		ad = ins[13:9] == 5'h1f || ins[13:8] == 6'h07;
		an = ins[13:8] == 6'h39 || ins[13:8] == 6'h05;
		bc = ins[13:10] == 4'h4;
		b = ins[13] ? ins[7:0] : f;
		r = acc & b;
		if (ad) begin s = acc + b; r = s[7:0]; c = s[8]; dc = acc[3:0] + b[3:0] > 15; end
		if (ad | an) z = r == 0;
		if (bc) r = f & ~(8'h01 << ins[9:7]);
		we = (ad | an) && !ins[13] && ins[7] || bc;
		ok = ad | an | bc;
		`CHK("done", ok, o_instr_done)
		`CHK("illegal", !ok, o_illegal)
		`CHK("we", we, o_file_we)
		if (we) `CHK("wdata", r, o_file_wdata)
		else if (ad | an) acc = r;
		`CHK("acc", acc, o_accumulator)
		`CHK("flags", {c, dc, z}, {o_carry_flag, o_nibble_carry_flag, o_zero_flag})
		$display("test %h ended", ins);
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(negedge i_mclk);
		i_reset = 0;
		// both add-immediate encodings, then carry and nibble carry together
		foreach (ops[j]) run(ops[j] | 14'h0185);
		run(14'h3f15);
		run(14'h395f);
		run(14'h3eff);
		run(14'h3e01);
		for (int i = 0; i < 8; i++) run({4'h4, i[2:0], 7'h09});
		run(14'h0000);
		run(14'h3a55);
		// valid low: the word must pass untouched for two whole instruction cycles
		i_instr = 14'h3e01;
		i_instr_valid = 0;
		repeat (8) begin
			@(negedge i_mclk);
			`CHK("idle done", 1'b0, o_instr_done | o_illegal)
			`CHK("idle acc", acc, o_accumulator)
		end
		// reset in mid-run clears accumulator and flags, then execution resumes
		run(14'h3eff);
		i_reset = 1;
		repeat (2) @(negedge i_mclk);
		`CHK("reset state", 12'h000, {o_accumulator, o_carry_flag, o_nibble_carry_flag, o_zero_flag, o_instr_done})
		i_reset = 0;
		acc = 0;
		c = 0;
		dc = 0;
		z = 0;
		run(14'h3f15);
		repeat (80) begin
			t = $random(seed);
			run(ops[t[18:16] % 5] | t[13:0] & msk[t[18:16] % 5]);
		end
		print_verdict();
	end
endmodule
bind abd_datapath abd_datapath_sva sva (.i_mclk(i_mclk), .i_reset(i_reset),
	.i_instr_valid(i_instr_valid), .o_file_we(o_file_we), .o_carry_flag(o_carry_flag),
	.o_nibble_carry_flag(o_nibble_carry_flag), .o_zero_flag(o_zero_flag),
	.o_cycle_start(o_cycle_start), .o_instr_done(o_instr_done), .o_illegal(o_illegal),
	.i_instr(i_instr), .i_file_rdata(i_file_rdata), .o_file_wdata(o_file_wdata),
	.o_accumulator(o_accumulator));
`default_nettype wire
